/* File: include/rsp_params.svh */
// Offsets, field positions, reset values and timing counts for the status/serial block.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef RSP_PARAMS_SVH
`define RSP_PARAMS_SVH
`define RSP_ADDR_CTRL       8'h6A
`define RSP_ADDR_WORD16     8'h6B
`define RSP_ADDR_READ       8'h6C
`define RSP_ADDR_BITS       5'h08
`define RSP_WORD_BITS       5'h10
`define RSP_CTRL_MODE_MSB   2
`define RSP_CTRL_PT2_BIT    2
`define RSP_CTRL_EASE_BIT   3
`define RSP_CTRL_STRICT_BIT 4
`define RSP_CTRL_TEST_LSB   5
`define RSP_CTRL_TEST_MSB   8
`define RSP_CTRL_RESET      16'h0003
`define RSP_SET_LAST        6'h2F
`define RSP_ERR_LVL1        6'h14
`define RSP_ERR_LVL2        6'h28
`define RSP_CLK_MHZ         40
`define RSP_LOCK_PULSE_US   421
`define RSP_LOCK_PULSE_CYC  (`RSP_LOCK_PULSE_US * `RSP_CLK_MHZ)
`define RSP_WORD_W          16
`define RSP_FIFO_DEPTH      8
`endif

/* File: include/rsp_pkg.sv */
// Types used by the status/serial block; its bench does not use them.
// Assumes nothing beyond a SystemVerilog compiler.
package rsp_pkg;
  typedef enum logic [1:0] {
    RSP_ST_ADDR = 2'h0,
    RSP_ST_IN   = 2'h1,
    RSP_ST_OUT  = 2'h3,
    RSP_ST_SKIP = 2'h2
  } rsp_ser_state_t;
  typedef enum logic [1:0] {
    RSP_RES_UNCORR = 2'h0,
    RSP_RES_CORR   = 2'h1,
    RSP_RES_CLEAN  = 2'h2
  } rsp_result_t;
endpackage

/* File: design/rsp_status_serial.sv */
// Status pin encoder, block data FIFO and addressed three-wire serial port of the data decoder.
// Assumes block results arrive on clock_i; serial and test pins are asynchronous and get synchronised.
`include "rsp_params.svh"

module rsp_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clock_i,
  input  wire logic         resetn_i,
  // Fill side
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Drain side
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          rdy_reg, rdy_next;
  logic          push, pop;

  assign push        = in_valid_i && rdy_reg;
  assign pop         = out_ready_i && (cnt_reg != '0);
  assign in_ready_o  = rdy_reg;
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o  = mem[rp_reg];

  always_comb begin
    wp_next  = push ? ((wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next  = pop ? ((rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = CW'(cnt_reg + CW'(push) - CW'(pop));
    rdy_next = cnt_next != CW'(D);
  end

  // Memory has no reset; only the pointers, count and ready flag need defined values
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b1;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end
endmodule

module rsp_status_serial #(
  parameter int LOCK_PULSE_CYC = `RSP_LOCK_PULSE_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // Decoded block results
  input  wire logic        blk_valid_i,
  output logic             blk_ready_o,
  input  wire logic [15:0] blk_data_i,
  input  wire logic [1:0]  blk_result_i,
  input  wire logic        blk_pre_err_i,
  input  wire logic        blk_sync_i,
  input  wire logic        traffic_alert_flag_i,
  input  wire logic        ari_carrier_i,
  input  wire logic        rds_detect_i,
  input  wire logic        rds_detect_strict_i,
  input  wire logic        soft_strong_i,
  input  wire logic        soft_weak_i,
  // Test and standby pins
  input  wire logic        factory_test_pin_i,
  input  wire logic        standby_pin_i,
  // Serial bus pins
  input  wire logic        select_pin_i,
  input  wire logic        shift_tick_pin_i,
  input  wire logic        serial_input_pin_i,
  output logic             serial_output_out_o,
  output logic             serial_output_oe_o,
  // Open-drain status pins; the last output below is a plain push-pull level
  output logic             status_pin_a_out_o,
  output logic             status_pin_a_oe_o,
  output logic             status_pin_b_out_o,
  output logic             status_pin_b_oe_o,
  output logic             lock_pin_out_o,
  output logic             lock_pin_oe_o,
  output logic             signal_presence_pin_out_o,
  output logic             signal_presence_pin_oe_o,
  output logic             soft_reliability_output_o,
  // Host-written words
  output logic [15:0]      word16_o,
  output logic             word16_stb_o,
  output logic [3:0]       test_bits_o
);
  localparam int PW = 15;

  function automatic logic [1:0] base_mode(input logic [2:0] m);
    base_mode = m[1:0];
  endfunction

  function automatic rsp_pkg::rsp_ser_state_t decode(input logic [7:0] a);
    case (a)
      `RSP_ADDR_CTRL:   decode = rsp_pkg::RSP_ST_IN;
      `RSP_ADDR_WORD16: decode = rsp_pkg::RSP_ST_IN;
      `RSP_ADDR_READ:   decode = rsp_pkg::RSP_ST_OUT;
      default:          decode = rsp_pkg::RSP_ST_SKIP;
    endcase
  endfunction

  // Pin synchronisers: select, tick, data, standby, test
  logic [4:0] s1_reg, s2_reg;
  logic       ce_s, cl_s, di_s, link_ok;
  logic       ce_prev_reg, cl_prev_reg, ce_rise, ce_fall, cl_rise;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg      <= 5'h00;
      s2_reg      <= 5'h00;
      ce_prev_reg <= 1'b0;
      cl_prev_reg <= 1'b0;
    end else begin
      s1_reg      <= {factory_test_pin_i, standby_pin_i, serial_input_pin_i, shift_tick_pin_i, select_pin_i};
      s2_reg      <= s1_reg;
      ce_prev_reg <= s2_reg[0];
      cl_prev_reg <= s2_reg[1];
    end
  end
  assign ce_s    = s2_reg[0];
  assign cl_s    = s2_reg[1];
  assign di_s    = s2_reg[2];
  assign link_ok = !s2_reg[3] && !s2_reg[4];
  assign ce_rise = ce_s && !ce_prev_reg;
  assign ce_fall = !ce_s && ce_prev_reg;
  assign cl_rise = cl_s && !cl_prev_reg;

  // Block data buffer
  logic        f_valid, f_pop;
  logic [15:0] f_data;
  rsp_fifo #(.W(`RSP_WORD_W), .D(`RSP_FIFO_DEPTH)) u_fifo (
    .clock_i    (clock_i),
    .resetn_i   (resetn_i),
    .in_valid_i (blk_valid_i),
    .in_data_i  (blk_data_i),
    .in_ready_o (blk_ready_o),
    .out_valid_o(f_valid),
    .out_data_o (f_data),
    .out_ready_i(f_pop)
  );

  // Serial port
  rsp_pkg::rsp_ser_state_t st_reg, st_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [7:0]  addr_reg, addr_next;
  logic [15:0] sh_reg, sh_next, ctrl_reg, ctrl_next, word_reg, word_next;
  logic        stb_reg, stb_next, do_oe_reg, do_oe_next;
  logic        ld_reg, ld_next;

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    addr_next = addr_reg;
    sh_next   = sh_reg;
    ctrl_next = ctrl_reg;
    word_next = word_reg;
    stb_next  = 1'b0;
    ld_next   = ld_reg;
    f_pop     = 1'b0;
    case (st_reg)
      rsp_pkg::RSP_ST_ADDR: begin
        if (ce_rise) begin
          st_next  = (cnt_reg == `RSP_ADDR_BITS) ? decode(addr_reg) : rsp_pkg::RSP_ST_SKIP;
          cnt_next = (st_next == rsp_pkg::RSP_ST_OUT) ? `RSP_WORD_BITS : 5'h00;
        end else if (!ce_s && cl_rise && cnt_reg != `RSP_ADDR_BITS) begin
          addr_next = {di_s, addr_reg[7:1]};
          cnt_next  = cnt_reg + 5'h01;
        end
      end
      rsp_pkg::RSP_ST_IN: begin
        if (ce_fall) begin
          st_next  = rsp_pkg::RSP_ST_ADDR;
          cnt_next = 5'h00;
          if (cnt_reg == `RSP_WORD_BITS && addr_reg == `RSP_ADDR_CTRL) begin
            ctrl_next = sh_reg;
          end else if (cnt_reg == `RSP_WORD_BITS) begin
            word_next = sh_reg;
            stb_next  = 1'b1;
          end
        end else if (cl_rise) begin
          sh_next  = {di_s, sh_reg[15:1]};
          cnt_next = (cnt_reg == `RSP_WORD_BITS) ? cnt_reg : cnt_reg + 5'h01;
        end
      end
      rsp_pkg::RSP_ST_OUT: begin
        if (ce_fall) begin
          st_next  = rsp_pkg::RSP_ST_ADDR;
          cnt_next = 5'h00;
        end else if (cnt_reg == `RSP_WORD_BITS) begin
          // Only a peek: a word leaves the buffer after its last bit, so a host stopping early loses nothing
          // An empty buffer reads as zeros so a sharing host can tell who asked
          ld_next  = f_valid;
          sh_next  = f_valid ? f_data : 16'h0000;
          cnt_next = 5'h00;
        end else if (cl_rise) begin
          f_pop    = ld_reg && (cnt_reg == `RSP_WORD_BITS - 5'h01);
          sh_next  = {1'b0, sh_reg[15:1]};
          cnt_next = cnt_reg + 5'h01;
        end
      end
      rsp_pkg::RSP_ST_SKIP: begin
        if (ce_fall) begin
          st_next  = rsp_pkg::RSP_ST_ADDR;
          cnt_next = 5'h00;
        end
      end
      default: begin
        st_next  = rsp_pkg::RSP_ST_ADDR;
        cnt_next = 5'h00;
      end
    endcase
    if (!link_ok) begin
      st_next  = rsp_pkg::RSP_ST_ADDR;
      cnt_next = 5'h00;
    end
    do_oe_next = (st_next == rsp_pkg::RSP_ST_OUT) && !sh_next[0];
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg    <= rsp_pkg::RSP_ST_ADDR;
      cnt_reg   <= 5'h00;
      addr_reg  <= 8'h00;
      sh_reg    <= 16'h0000;
      ctrl_reg  <= `RSP_CTRL_RESET;
      word_reg  <= 16'h0000;
      stb_reg   <= 1'b0;
      do_oe_reg <= 1'b0;
      ld_reg    <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      addr_reg  <= addr_next;
      sh_reg    <= sh_next;
      ctrl_reg  <= ctrl_next;
      word_reg  <= word_next;
      stb_reg   <= stb_next;
      do_oe_reg <= do_oe_next;
      ld_reg    <= ld_next;
    end
  end

  // Status encoding
  logic [2:0]    mode;
  logic [1:0]    bm;
  logic          inv;
  logic          sp_reg, sp_next;
  rsp_pkg::rsp_result_t res_reg, res_next;
  logic [5:0]    blk_reg, blk_next, err_reg, err_next, err_acc;
  logic [1:0]    code_reg, code_next;
  logic [PW-1:0] pul_reg, pul_next;
  logic          a_oe_reg, a_oe_next, b_oe_reg, b_oe_next, lk_oe_reg, lk_oe_next;
  logic          pr_oe_reg, pr_oe_next, soft_reg, soft_next;
  logic          lv_a, lv_b, lv_lk;

  assign mode = ctrl_reg[`RSP_CTRL_MODE_MSB:0];
  assign bm   = base_mode(mode);
  assign inv  = ctrl_reg[`RSP_CTRL_PT2_BIT];

  always_comb begin
    sp_next   = sp_reg;
    res_next  = res_reg;
    blk_next  = blk_reg;
    err_next  = err_reg;
    code_next = code_reg;
    pul_next  = (pul_reg != '0) ? pul_reg - 1'b1 : pul_reg;
    err_acc   = err_reg + {5'h00, blk_pre_err_i};
    if (blk_valid_i) begin
      sp_next  = blk_sync_i;
      res_next = rsp_pkg::rsp_result_t'(blk_result_i);
      if (blk_sync_i) begin
        pul_next = PW'(LOCK_PULSE_CYC);
      end
      if (blk_reg == `RSP_SET_LAST) begin
        blk_next  = 6'h00;
        err_next  = 6'h00;
        code_next = (err_acc == 6'h00) ? 2'h0 : (err_acc <= `RSP_ERR_LVL1) ? 2'h1 :
                    (err_acc <= `RSP_ERR_LVL2) ? 2'h2 : 2'h3;
      end else begin
        blk_next = blk_reg + 6'h01;
        err_next = err_acc;
      end
    end
    // Levels are the wanted pin levels; a released pin reads high through the pull-up
    lv_a = 1'b1;
    lv_b = 1'b1;
    if (mode == 3'h4) begin
      {lv_a, lv_b} = code_reg;
    end else begin
      case (bm)
        2'h1: lv_b = !traffic_alert_flag_i ^ inv;
        2'h2: lv_b = !ari_carrier_i ^ inv;
        2'h3: begin
          lv_a = (res_reg != rsp_pkg::RSP_RES_UNCORR) ^ inv;
          lv_b = (res_reg == rsp_pkg::RSP_RES_CLEAN) ^ inv;
        end
        default: lv_a = 1'b1;
      endcase
    end
    lv_lk      = ((bm == 2'h3) ? (!sp_reg || pul_reg != '0) : !sp_reg) ^ inv;
    a_oe_next  = !lv_a;
    b_oe_next  = !lv_b;
    lk_oe_next = !lv_lk;
    pr_oe_next = (ctrl_reg[`RSP_CTRL_STRICT_BIT] ? rds_detect_strict_i : rds_detect_i) ^ inv;
    soft_next  = ctrl_reg[`RSP_CTRL_EASE_BIT] ? soft_weak_i : soft_strong_i;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sp_reg    <= 1'b0;
      res_reg   <= rsp_pkg::RSP_RES_UNCORR;
      blk_reg   <= 6'h00;
      err_reg   <= 6'h00;
      code_reg  <= 2'h0;
      pul_reg   <= '0;
      a_oe_reg  <= 1'b0;
      b_oe_reg  <= 1'b0;
      lk_oe_reg <= 1'b0;
      pr_oe_reg <= 1'b0;
      soft_reg  <= 1'b0;
    end else begin
      sp_reg    <= sp_next;
      res_reg   <= res_next;
      blk_reg   <= blk_next;
      err_reg   <= err_next;
      code_reg  <= code_next;
      pul_reg   <= pul_next;
      a_oe_reg  <= a_oe_next;
      b_oe_reg  <= b_oe_next;
      lk_oe_reg <= lk_oe_next;
      pr_oe_reg <= pr_oe_next;
      soft_reg  <= soft_next;
    end
  end

  // Open-drain pins only ever pull low
  assign serial_output_out_o       = 1'b0;
  assign status_pin_a_out_o        = 1'b0;
  assign status_pin_b_out_o        = 1'b0;
  assign lock_pin_out_o            = 1'b0;
  assign signal_presence_pin_out_o = 1'b0;
  assign serial_output_oe_o        = do_oe_reg;
  assign status_pin_a_oe_o         = a_oe_reg;
  assign status_pin_b_oe_o         = b_oe_reg;
  assign lock_pin_oe_o             = lk_oe_reg;
  assign signal_presence_pin_oe_o  = pr_oe_reg;
  assign soft_reliability_output_o = soft_reg;
  assign word16_o                  = word_reg;
  assign word16_stb_o              = stb_reg;
  assign test_bits_o               = ctrl_reg[`RSP_CTRL_TEST_MSB:`RSP_CTRL_TEST_LSB];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_mode1_ta;
    mode == 3'h1 |=> status_pin_b_oe_o == $past(traffic_alert_flag_i);
  endproperty
  a_mode1_ta: assert property (p_mode1_ta) else $error("pin B wrong in mode 1");
  property p_mode2_ari;
    mode == 3'h2 |=> status_pin_b_oe_o == $past(ari_carrier_i) && !status_pin_a_oe_o;
  endproperty
  a_mode2_ari: assert property (p_mode2_ari) else $error("pin B wrong in mode 2");
  property p_mode3_res;
    mode == 3'h3 && blk_valid_i ##1 mode == 3'h3 |=> status_pin_a_oe_o == ($past(blk_result_i, 2) == 2'h0);
  endproperty
  a_mode3_res: assert property (p_mode3_res) else $error("pin A wrong for block result");
  property p_mode4_code;
    mode == 3'h4 |=> {status_pin_a_oe_o, status_pin_b_oe_o} == ~$past(code_reg);
  endproperty
  a_mode4_code: assert property (p_mode4_code) else $error("error count pins wrong");
  property p_lock_prev;
    mode == 3'h0 && blk_valid_i ##1 mode == 3'h0 |=> lock_pin_oe_o == $past(blk_sync_i, 2);
  endproperty
  a_lock_prev: assert property (p_lock_prev) else $error("lock pin not from previous block");
  property p_lock_pulse;
    mode == 3'h3 && blk_valid_i && blk_sync_i ##1 mode == 3'h3 |=> !lock_pin_oe_o && pul_reg == PW'(LOCK_PULSE_CYC - 1);
  endproperty
  a_lock_pulse: assert property (p_lock_pulse) else $error("lock pulse not started");
  property p_presence;
    ctrl_reg[`RSP_CTRL_STRICT_BIT] |=> signal_presence_pin_oe_o == ($past(rds_detect_strict_i) ^ $past(inv));
  endproperty
  a_presence: assert property (p_presence) else $error("presence pin ignores strict bit");
  property p_soft;
    ctrl_reg[`RSP_CTRL_EASE_BIT] |=> soft_reliability_output_o == $past(soft_weak_i);
  endproperty
  a_soft: assert property (p_soft) else $error("soft output ignores ease bit");
  property p_skip_quiet;
    st_reg == rsp_pkg::RSP_ST_SKIP |=> !serial_output_oe_o;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("serial output driven for unknown address");
  property p_addr_ctrl;
    st_reg == rsp_pkg::RSP_ST_ADDR && ce_rise && link_ok && cnt_reg == `RSP_ADDR_BITS &&
      addr_reg == `RSP_ADDR_CTRL |=> st_reg == rsp_pkg::RSP_ST_IN;
  endproperty
  a_addr_ctrl: assert property (p_addr_ctrl) else $error("control address not taken");
  property p_standby;
    !link_ok |=> st_reg == rsp_pkg::RSP_ST_ADDR && cnt_reg == 5'h00;
  endproperty
  a_standby: assert property (p_standby) else $error("transfer accepted in standby");
  c_read: cover property (st_reg == rsp_pkg::RSP_ST_OUT && f_pop);
  c_ctrl_write: cover property (st_reg == rsp_pkg::RSP_ST_IN && ce_fall && cnt_reg == `RSP_WORD_BITS);
  c_err_top: cover property (code_reg == 2'h3);
  c_lock_pulse_end: cover property (pul_reg == PW'(1) && mode == 3'h3);
endmodule

/* File: testbench/rsp_host_model.sv */
// Behavioural host on the three-wire addressed serial bus.
// Assumes the return line is resolved by the bench (open drain, pull-up).
module rsp_host_model (
  // Lines driven by the host
  output logic      select_o,
  output logic      tick_o,
  output logic      sdata_o,
  // Resolved return line
  input  wire logic sout_i
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 100;

  // Tick stands still low outside frames
  initial begin
    select_o = 1'b0;
    tick_o   = 1'b0;
    sdata_o  = 1'b1;
  end

  // Data set while tick is low, return line read just before the rise
  task automatic bit_cycle(input logic d, output logic q);
    sdata_o = d;
    #HALF;
    q = sout_i;
    tick_o = 1'b1;
    #HALF;
    tick_o = 1'b0;
  endtask

  // Address with select low, data with select high; n bits LSB first
  task automatic xfer(input logic [7:0] adr, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    int   i;
    dout = 32'h00000000;
    // Odd offset keeps the bus unrelated in phase to the core clock
    #13;
    for (i = 0; i < 8; i++) begin
      bit_cycle(adr[i], q);
    end
    select_o = 1'b1;
    #(3 * HALF);
    for (i = 0; i < n; i++) begin
      bit_cycle(din[i], q);
      dout[i] = q;
    end
    #HALF;
    select_o = 1'b0;
    // Released data line must not keep its last value
    sdata_o = ~sdata_o;
    #(2 * HALF);
  endtask
endmodule

/* File: testbench/tb_rsp_status_serial.sv */
// Self-checking bench for the status pins, block FIFO and serial port.
// Assumes the host model drives the bus; test bits always written as zero.
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module tb_rsp_status_serial;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        blk_valid = 1'b0;
  logic [15:0] blk_data = 16'h0000;
  logic [1:0]  blk_result = 2'h0;
  logic        blk_pre_err = 1'b0;
  logic        blk_sync = 1'b0;
  logic        traffic = 1'b0;
  logic        ari = 1'b0;
  logic        det = 1'b0;
  logic        det_strict = 1'b0;
  logic        soft_strong = 1'b0;
  logic        soft_weak = 1'b0;
  logic        ftest = 1'b0;
  logic        standby = 1'b0;
  wire         sel_w, tick_w, sdi_w, sout_w;
  wire         sout_oe, a_oe, b_oe, lock_oe, pres_oe, blk_ready, soft_o, stb;
  wire  [15:0] word16;
  wire  [3:0]  test_bits;
  wire  [4:0]  od_out;
  int          n_stb = 0;
  logic [31:0] q;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          nblk = 0;
  int          i, j, b;
  int          ks[7] = '{0, 1, 20, 21, 40, 41, 48};
  logic [1:0]  cs[7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};

  always #12.5 clock_i = ~clock_i;
  // Open-drain return line with pull-up
  // Shared-bus style: plain wires from the host, wired-low return line
  assign sout_w = sout_oe ? 1'b0 : 1'b1;

  // Counts strobes so a lost or doubled word write shows up
  always @(posedge clock_i) begin
    if (stb) begin
      n_stb++;
    end
  end

  rsp_host_model i_host (.select_o(sel_w), .tick_o(tick_w), .sdata_o(sdi_w), .sout_i(sout_w));

  rsp_status_serial #(.LOCK_PULSE_CYC(20)) i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i),
    .blk_valid_i(blk_valid), .blk_ready_o(blk_ready), .blk_data_i(blk_data),
    .blk_result_i(blk_result), .blk_pre_err_i(blk_pre_err), .blk_sync_i(blk_sync),
    .traffic_alert_flag_i(traffic), .ari_carrier_i(ari), .rds_detect_i(det),
    .rds_detect_strict_i(det_strict), .soft_strong_i(soft_strong), .soft_weak_i(soft_weak),
    .factory_test_pin_i(ftest), .standby_pin_i(standby),
    .select_pin_i(sel_w), .shift_tick_pin_i(tick_w), .serial_input_pin_i(sdi_w),
    .serial_output_out_o(od_out[0]), .serial_output_oe_o(sout_oe),
    .status_pin_a_out_o(od_out[1]), .status_pin_a_oe_o(a_oe),
    .status_pin_b_out_o(od_out[2]), .status_pin_b_oe_o(b_oe),
    .lock_pin_out_o(od_out[3]), .lock_pin_oe_o(lock_oe),
    .signal_presence_pin_out_o(od_out[4]), .signal_presence_pin_oe_o(pres_oe),
    .soft_reliability_output_o(soft_o), .word16_o(word16), .word16_stb_o(stb), .test_bits_o(test_bits)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // One decoded block; outputs are sampled two edges after the pulse ends
  task automatic blk(input logic [15:0] d, input logic [1:0] res, input logic err, input logic sync);
    @(posedge clock_i);
    blk_valid   <= 1'b1;
    blk_data    <= d;
    blk_result  <= res;
    blk_pre_err <= err;
    blk_sync    <= sync;
    @(posedge clock_i);
    blk_valid <= 1'b0;
    nblk++;
    cyc(2);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] d);
    logic [31:0] r;
    i_host.xfer(adr, 16, {16'h0000, d}, r);
    cyc(2);
  endtask

  task automatic rd(input logic [7:0] adr, input int n, output logic [31:0] r);
    i_host.xfer(adr, n, 32'h00000000, r);
  endtask

  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run needs under a fifth of this
  initial begin
    #1ms;
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    cyc(2);
    `CHK(a_oe, 1'b1)
    `CHK(b_oe, 1'b1)
    `CHK(lock_oe, 1'b0)
    `CHK(soft_o, 1'b0)
    `CHK(test_bits, 4'h0)
    `CHK(od_out, 5'h00)
    tdone("reset");
    // Mode 3: all three results, lock pulse, FIFO filled past its depth
    for (i = 0; i < 9; i++) begin
      blk(16'hC100 + 16'(i), 2'(i % 3), 1'b0, 1'b1);
      `CHK(a_oe, (i % 3) == 0)
      `CHK(b_oe, (i % 3) != 2)
      `CHK(lock_oe, 1'b0)
    end
    `CHK(blk_ready, 1'b0)
    cyc(25);
    `CHK(lock_oe, 1'b1)
    blk(16'hDEAD, 2'h2, 1'b0, 1'b0);
    cyc(25);
    `CHK(lock_oe, 1'b0)
    tdone("mode3");
    // Reads pop one word per 16 ticks; the seventh reads two back to back
    for (i = 0; i < 6; i++) begin
      rd(8'h6C, 16, q);
      `CHK(q[15:0], 16'hC100 + 16'(i))
    end
    rd(8'h6C, 32, q);
    `CHK(q, 32'hC107C106)
    rd(8'h6C, 16, q);
    `CHK(q[15:0], 16'h0000)
    `CHK(blk_ready, 1'b1)
    rd(8'h6D, 16, q);
    `CHK(q[15:0], 16'hFFFF)
    tdone("read");
    wr(8'h6B, 16'hA5C3);
    `CHK(word16, 16'hA5C3)
    `CHK(n_stb, 1)
    wr(8'h6D, 16'h1234);
    `CHK(word16, 16'hA5C3)
    for (j = 0; j < 2; j++) begin
      @(posedge clock_i);
      standby <= (j == 0);
      ftest   <= (j == 1);
      wr(8'h6B, 16'h0F0F);
      `CHK(word16, 16'hA5C3)
      @(posedge clock_i);
      standby <= 1'b0;
      ftest   <= 1'b0;
    end
    wr(8'h6B, 16'h5A3C);
    `CHK(word16, 16'h5A3C)
    `CHK(n_stb, 2)
    tdone("write");
    // Mode 1 then its inverted twin, mode 5
    wr(8'h6A, 16'h0001);
    for (j = 0; j < 2; j++) begin
      @(posedge clock_i);
      traffic <= j[0];
      blk(16'h0000, 2'h2, 1'b0, j[0]);
      `CHK(b_oe, j[0])
      `CHK(lock_oe, j[0])
    end
    @(posedge clock_i);
    det <= 1'b1;
    cyc(2);
    `CHK(pres_oe, 1'b1)
    wr(8'h6A, 16'h0005);
    `CHK(b_oe, 1'b0)
    `CHK(lock_oe, 1'b0)
    `CHK(pres_oe, 1'b0)
    tdone("mode1");
    // Mode 0 leaves pins A and B released; mode 7 is mode 3 inverted
    wr(8'h6A, 16'h0000);
    blk(16'h0000, 2'h2, 1'b0, 1'b1);
    `CHK(lock_oe, 1'b1)
    `CHK({a_oe, b_oe}, 2'h0)
    blk(16'h0000, 2'h2, 1'b0, 1'b0);
    `CHK(lock_oe, 1'b0)
    wr(8'h6A, 16'h0007);
    blk(16'h0000, 2'h0, 1'b0, 1'b1);
    `CHK({a_oe, b_oe}, 2'h0)
    `CHK(lock_oe, 1'b1)
    tdone("mode0_mode7");
    // Mode 2, strict detection and soft ease
    wr(8'h6A, 16'h0002);
    for (j = 0; j < 2; j++) begin
      @(posedge clock_i);
      ari <= j[0];
      soft_weak <= 1'b1;
      cyc(2);
      `CHK(b_oe, j[0])
    end
    `CHK(soft_o, 1'b0)
    wr(8'h6A, 16'h0006);
    `CHK(b_oe, 1'b0)
    wr(8'h6A, 16'h0012);
    `CHK(pres_oe, 1'b0)
    wr(8'h6A, 16'h000A);
    `CHK(pres_oe, 1'b1)
    `CHK(soft_o, 1'b1)
    `CHK(test_bits, 4'h0)
    tdone("mode2");
    // Mode 4 with polarity set: sets aligned to the count since reset
    wr(8'h6A, 16'h0004);
    while (nblk % 48 != 0) begin
      blk(16'h0000, 2'h2, 1'b0, 1'b1);
    end
    for (i = 0; i < 7; i++) begin
      for (b = 0; b < 48; b++) begin
        blk(16'h0000, 2'h2, b < ks[i], 1'b1);
      end
      `CHK({a_oe, b_oe}, ~cs[i])
    end
    tdone("mode4");
    end_sim();
  end
endmodule
